// >>> design/bpsc_fan_chan.sv
// One fan channel: PWM drive and tachometer pulse counter.
`timescale 1ns/10ps
`default_nettype none

module bpsc_fan_chan #(
  parameter int unsigned PWM_W = 8,
  parameter int unsigned TACH_W = 16,
  parameter int unsigned WIN_CYC = 50_000_000
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [PWM_W-1:0] duty_i,
  input wire logic tach_i,
  output logic pwm_o,
  output logic [TACH_W-1:0] tach_cnt_o
);

  typedef struct packed {
    logic [1:0] tsync;
    logic tlast;
    logic [PWM_W-1:0] phase;
    logic [31:0] win;
    logic [TACH_W-1:0] acc;
    logic [TACH_W-1:0] cnt;
    logic pwm;
  } bpsc_fan_st_t;

  bpsc_fan_st_t st_ff;
  bpsc_fan_st_t nxt_st;

  // Tach is a pin: synchronised, then edges counted over a fixed window.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tsync = {st_ff.tsync[0], tach_i};
    nxt_st.tlast = st_ff.tsync[1];
    nxt_st.phase = st_ff.phase + {{(PWM_W-1){1'b0}}, 1'b1};
    // A full-scale duty keeps the fan hard on; zero switches it off.
    nxt_st.pwm = enable_i && ((&duty_i) || (st_ff.phase < duty_i));
    if (st_ff.tsync[1] && !st_ff.tlast) begin
      nxt_st.acc = st_ff.acc + {{(TACH_W-1){1'b0}}, 1'b1};
    end
    if (st_ff.win >= WIN_CYC - 1) begin
      nxt_st.win = 32'h0;
      nxt_st.cnt = nxt_st.acc;
      nxt_st.acc = '0;
    end else begin
      nxt_st.win = st_ff.win + 32'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pwm_o = st_ff.pwm;
  assign tach_cnt_o = st_ff.cnt;

endmodule // bpsc_fan_chan

`default_nettype wire

// >>> design/bpsc_pkg.sv
// Package of constants and carrier types for the board power state controller.
package bpsc_pkg;

  // Clock rate and press timing.
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SHORT_PRESS_S = 4;
  localparam int unsigned LONG_PRESS_S = 6;
  localparam longint unsigned SHORT_PRESS_CYC = longint'(SHORT_PRESS_S) * CLK_HZ;
  localparam longint unsigned LONG_PRESS_CYC = longint'(LONG_PRESS_S) * CLK_HZ;
  localparam int unsigned PRESS_CNT_W = 32;

  // Fan channel defaults.
  localparam int unsigned FAN_NUM = 4;
  localparam int unsigned PWM_W = 8;
  localparam int unsigned TACH_W = 16;
  localparam int unsigned TACH_WIN_CYC = 50_000_000;

  // Restore policy after AC returns.
  localparam logic [1:0] RESTORE_LAST = 2'h0;
  localparam logic [1:0] RESTORE_OFF = 2'h1;
  localparam logic [1:0] RESTORE_ON = 2'h2;

  // Power states, one-hot.
  typedef enum logic [3:0] {
    PST_S0 = 4'h1,
    PST_S3 = 4'h2,
    PST_S4 = 4'h4,
    PST_S5 = 4'h8
  } bpsc_pstate_t;

  // Wake sources.
  typedef struct packed {
    logic lan;
    logic pcie;
    logic cir;
    logic usb;
  } bpsc_wake_t;

  // Commands from the operating system.
  typedef struct packed {
    logic sleep_s3;
    logic sleep_s4;
    logic soft_off;
  } bpsc_oscmd_t;

endpackage : bpsc_pkg

// >>> design/bpsc_top.sv
// Board power state controller: switch timing, wake, supply, restore and fans.
//
// Function
// - Press under four seconds: off to on, on to sleep, sleep to on.
// - Press over six seconds in working or sleep forces soft-off.
// - In S3, S4, S5 processor and devices unpowered; wake logic stays supplied.
// - LAN, PCIe wake, IR wake from S3/S4/S5; USB wakes only from S3.
// - Off command makes supply drop non-standby rails, standby kept.
// - After AC returns, restore previous on/off state per restore setting.
// - All fans run in S0 at the shared duty; zero duty stops them.
// - All fans off when off or in S3, S4, S5.
// - Each fan channel provides a measured tachometer count.
// - Each fan supports PWM open-loop speed or full on/off.
`timescale 1ns/10ps
`default_nettype none

module bpsc_top
  import bpsc_pkg::*;
#(
  parameter longint unsigned SHORT_CYC = bpsc_pkg::SHORT_PRESS_CYC,
  parameter longint unsigned LONG_CYC = bpsc_pkg::LONG_PRESS_CYC,
  parameter int unsigned TACH_WIN = bpsc_pkg::TACH_WIN_CYC,
  parameter int unsigned NFAN = bpsc_pkg::FAN_NUM
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic pwr_btn_n_i,
  input wire bpsc_pkg::bpsc_wake_t wake_i,
  input wire bpsc_pkg::bpsc_oscmd_t oscmd_i,
  input wire logic [1:0] restore_mode_i,
  input wire logic last_on_i,
  input wire logic [bpsc_pkg::PWM_W-1:0] fan_duty_i,
  input wire logic [NFAN-1:0] fan_tach_i,
  output logic main_rails_on_o,
  output logic cpu_pwr_on_o,
  output logic wake_logic_pwr_o,
  output logic [3:0] pstate_o,
  output logic last_on_o,
  output logic [NFAN-1:0] fan_pwm_o,
  output logic [NFAN*bpsc_pkg::TACH_W-1:0] fan_tach_cnt_o
);
  import bpsc_pkg::*;

  // Whole controller state, registered in one process.
  typedef struct packed {
    bpsc_pstate_t pst;
    logic booted;
    logic [1:0] bsync;
    logic [3:0] w1;
    logic [3:0] w2;
    logic [PRESS_CNT_W-1:0] press;
    logic long_done;
    logic rails;
    logic last_on;
    logic fan_en;
  } bpsc_st_t;

  bpsc_st_t st_ff;
  bpsc_st_t nxt_st;
  logic pressed;
  logic released;
  logic wake_hit;

  // Saturating increment so a stuck button cannot wrap the counter.
  function automatic logic [PRESS_CNT_W-1:0] sat_inc(input logic [PRESS_CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + {{(PRESS_CNT_W-1){1'b0}}, 1'b1};
  endfunction

  // True when a count has reached a cycle threshold.
  function automatic logic reached(input logic [PRESS_CNT_W-1:0] v,
                                   input longint unsigned lim);
    reached = (longint'(v) >= lim);
  endfunction

  assign pressed = st_ff.bsync[1];
  assign released = !st_ff.bsync[1] && (st_ff.press != '0);

  // Wake qualification per sleeping state; USB only counts from S3.
  always_comb begin
    wake_hit = 1'b0;
    case (st_ff.pst)
      PST_S3: wake_hit = st_ff.w2[3] | st_ff.w2[2] | st_ff.w2[1] | st_ff.w2[0];
      PST_S4: wake_hit = st_ff.w2[3] | st_ff.w2[2] | st_ff.w2[1];
      PST_S5: wake_hit = st_ff.w2[3] | st_ff.w2[2] | st_ff.w2[1];
      default: wake_hit = 1'b0;
    endcase
  end

  // Next-state logic. Pin inputs pass two flops before use.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.bsync = {st_ff.bsync[0], !pwr_btn_n_i};
    nxt_st.w2 = st_ff.w1;
    nxt_st.w1 = {wake_i.lan, wake_i.pcie, wake_i.cir, wake_i.usb};
    if (pressed) begin
      nxt_st.press = sat_inc(st_ff.press);
    end else begin
      nxt_st.press = '0;
      nxt_st.long_done = 1'b0;
    end
    if (!st_ff.booted) begin
      // First cycle after reset: decide state from the restore setting.
      nxt_st.booted = 1'b1;
      if (restore_mode_i == RESTORE_ON) begin
        nxt_st.pst = PST_S0;
      end else if (restore_mode_i == RESTORE_LAST && last_on_i) begin
        nxt_st.pst = PST_S0;
      end else begin
        nxt_st.pst = PST_S5;
      end
    end else if (pressed && !st_ff.long_done && reached(st_ff.press, LONG_CYC)
                 && st_ff.pst != PST_S5) begin
      // Fail-safe off fires while still held, without waiting for release.
      nxt_st.pst = PST_S5;
      nxt_st.long_done = 1'b1;
    end else if (released && !reached(st_ff.press, SHORT_CYC)) begin
      case (st_ff.pst)
        PST_S0: nxt_st.pst = PST_S3;
        PST_S3: nxt_st.pst = PST_S0;
        PST_S4: nxt_st.pst = PST_S0;
        PST_S5: nxt_st.pst = PST_S0;
        default: nxt_st.pst = PST_S5;
      endcase
    end else if (released) begin
      // Presses of four to six seconds, or past a fail-safe off, do nothing.
      nxt_st.pst = st_ff.pst;
    end else if (wake_hit) begin
      nxt_st.pst = PST_S0;
    end else if (st_ff.pst == PST_S0) begin
      // Operating system requests; soft-off has priority over sleep.
      if (oscmd_i.soft_off) begin
        nxt_st.pst = PST_S5;
      end else if (oscmd_i.sleep_s4) begin
        nxt_st.pst = PST_S4;
      end else if (oscmd_i.sleep_s3) begin
        nxt_st.pst = PST_S3;
      end
    end
    // Rails, fans and remembered state follow the next power state.
    nxt_st.rails = nxt_st.booted && (nxt_st.pst == PST_S0);
    nxt_st.fan_en = nxt_st.rails;
    if (nxt_st.booted) begin
      nxt_st.last_on = (nxt_st.pst == PST_S0);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= '{pst: PST_S5, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Per-fan channels; enable gates every channel by power state.
  for (genvar g = 0; g < NFAN; g++) begin : g_fan
    bpsc_fan_chan #(
      .PWM_W(PWM_W),
      .TACH_W(TACH_W),
      .WIN_CYC(TACH_WIN)
    ) u_fan (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .enable_i(st_ff.fan_en),
      .duty_i(fan_duty_i),
      .tach_i(fan_tach_i[g]),
      .pwm_o(fan_pwm_o[g]),
      .tach_cnt_o(fan_tach_cnt_o[g*TACH_W +: TACH_W])
    );
  end

  assign main_rails_on_o = st_ff.rails;
  assign cpu_pwr_on_o = st_ff.rails;
  assign wake_logic_pwr_o = st_ff.booted;
  assign pstate_o = st_ff.pst;
  assign last_on_o = st_ff.last_on;

endmodule // bpsc_top

`default_nettype wire

// >>> dv/bpsc_partner.sv
// Partner model: power switch, wake sources and spinning fans.
`timescale 1ns/10ps
`default_nettype none
module bpsc_partner
  import bpsc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [3:0] fan_pwm_i,
  output logic btn_n_o,
  output bpsc_pkg::bpsc_wake_t wake_o,
  output logic [3:0] tach_o
);
  // The switch line is pulled up, so it idles high.
  initial begin
    btn_n_o = 1'b1;
    wake_o = '0;
    tach_o = '0;
  end
  // A driven fan gives one tach rising edge every two cycles.
  always @(negedge mclk_i) begin
    tach_o <= fan_pwm_i & ~tach_o;
  end
  // Holds the switch down for n cycles.
  task automatic press(input int n);
    btn_n_o = 1'b0;
    repeat (n) @(negedge mclk_i);
    btn_n_o = 1'b1;
  endtask
  // Raises a wake source long enough to pass the synchroniser.
  task automatic wake(input bpsc_wake_t w);
    wake_o = w;
    repeat (5) @(negedge mclk_i);
    wake_o = '0;
  endtask
endmodule // bpsc_partner
`default_nettype wire

// >>> dv/bpsc_props.sv
// Checker of the power state controller outputs, bound to its top.
`timescale 1ns/10ps
`default_nettype none
module bpsc_props
  import bpsc_pkg::*;
#(
  parameter longint unsigned SHORT_CYC = 40,
  parameter longint unsigned LONG_CYC = 60,
  parameter int unsigned NFAN = 4
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic pwr_btn_n_i,
  input wire bpsc_pkg::bpsc_wake_t wake_i,
  input wire logic [bpsc_pkg::PWM_W-1:0] fan_duty_i,
  input wire logic main_rails_on_o,
  input wire logic cpu_pwr_on_o,
  input wire logic wake_logic_pwr_o,
  input wire logic [3:0] pstate_o,
  input wire logic [NFAN-1:0] fan_pwm_o
);
  logic [31:0] hold_ff;
  // Low samples of the switch; the value at release is the press length.
  always_ff @(posedge mclk_i) begin
    hold_ff <= (rst_i || pwr_btn_n_i) ? 32'h0 : hold_ff + 32'h1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Margins of four cycles absorb the two-flop switch synchroniser.
  sequence short_rel_s;
    $rose(pwr_btn_n_i) && hold_ff > 4 && hold_ff < SHORT_CYC - 4;
  endsequence
  sequence lan_off_s;
    (wake_i.lan && pstate_o == PST_S5)[*3];
  endsequence
  rails_cpu_a: assert property (cpu_pwr_on_o == main_rails_on_o) else $error("cpu power");
  rails_state_a: assert property (main_rails_on_o == (pstate_o == PST_S0)) else $error("rails");
  wake_pwr_a: assert property (!$past(rst_i) |-> wake_logic_pwr_o) else $error("wake power");
  fan_off_a: assert property ((pstate_o != PST_S0)[*2] |-> fan_pwm_o == '0) else $error("fan on");
  fan_on_a: assert property ((pstate_o == PST_S0 && fan_duty_i == 8'hFF)[*3] |->
    fan_pwm_o == '1) else $error("fan off");
  short_on_a: assert property (short_rel_s ##0 pstate_o == PST_S5 |->
    ##3 pstate_o == PST_S0) else $error("short press");
  mid_press_a: assert property ($rose(pwr_btn_n_i) && hold_ff >= SHORT_CYC + 4 &&
    hold_ff < LONG_CYC - 4 |=> $stable(pstate_o)[*4]) else $error("mid press");
  long_off_a: assert property (hold_ff == LONG_CYC + 6 |-> pstate_o == PST_S5) else $error("long");
  lan_wake_a: assert property (lan_off_s |-> ##[0:3] pstate_o == PST_S0) else $error("lan wake");
endmodule // bpsc_props
bind bpsc_top bpsc_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC), .NFAN(NFAN))
  u_props (.*);
`default_nettype wire

// >>> dv/bpsc_top_tb.sv
// Self-checking bench of the board power state controller.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, a, e); end end
module bpsc_top_tb;
  import bpsc_pkg::*;
  typedef struct packed {
    logic [1:0] op;
    logic [7:0] arg;
    logic [3:0] st;
  } bpsc_row_t;
  // Op 0 presses for arg cycles, 1 raises wake arg, 2 sends OS command arg.
  localparam bpsc_row_t ROWS [16] = '{{2'h0, 8'h0A, 4'h1}, {2'h0, 8'h0A, 4'h2},
    {2'h0, 8'h0A, 4'h1}, {2'h0, 8'h46, 4'h8}, {2'h0, 8'h32, 4'h8}, {2'h1, 8'h01, 4'h8},
    {2'h1, 8'h08, 4'h1}, {2'h2, 8'h04, 4'h2}, {2'h1, 8'h01, 4'h1}, {2'h2, 8'h02, 4'h4},
    {2'h1, 8'h01, 4'h4}, {2'h1, 8'h04, 4'h1}, {2'h2, 8'h01, 4'h8}, {2'h1, 8'h02, 4'h1},
    {2'h0, 8'h32, 4'h1}, {2'h0, 8'h46, 4'h8}};
  logic mclk_i;
  logic rst_i;
  logic last_on_i;
  logic [1:0] restore_mode_i;
  bpsc_oscmd_t oscmd_i;
  logic btn_n;
  bpsc_wake_t wake;
  logic [3:0] tach;
  logic [3:0] pwm;
  logic [3:0] pstate;
  logic rails;
  logic wake_pwr;
  logic [63:0] tach_cnt;
  logic [7:0] duty;
  logic last_on;
  int hi_cnt = 0;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  bpsc_top #(.SHORT_CYC(40), .LONG_CYC(60), .TACH_WIN(100)) u_dut (.mclk_i(mclk_i),
    .rst_i(rst_i), .pwr_btn_n_i(btn_n), .wake_i(wake), .oscmd_i(oscmd_i),
    .restore_mode_i(restore_mode_i), .last_on_i(last_on_i), .fan_duty_i(duty),
    .fan_tach_i(tach), .main_rails_on_o(rails), .cpu_pwr_on_o(), .wake_logic_pwr_o(wake_pwr),
    .pstate_o(pstate), .last_on_o(last_on), .fan_pwm_o(pwm), .fan_tach_cnt_o(tach_cnt));
  bpsc_partner u_far (.mclk_i(mclk_i), .fan_pwm_i(pwm), .btn_n_o(btn_n), .wake_o(wake),
    .tach_o(tach));
  // Free running 50 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // A hang past the ceiling counts as a mismatch.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Lets the change land, then checks state, rails and fans together.
  task automatic expect_st(input logic [3:0] st);
    repeat (8) @(negedge mclk_i);
    `CHK(pstate, st)
    `CHK(rails, st == 4'h1)
    `CHK(pwm, (st == 4'h1) ? 4'hF : 4'h0)
    `CHK(last_on, st == 4'h1)
  endtask
  initial begin
    rst_i = 1'b1;
    restore_mode_i = RESTORE_OFF;
    last_on_i = 1'b0;
    oscmd_i = '0;
    duty = 8'hFF;
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    expect_st(PST_S5);
    foreach (ROWS[i]) begin
      case (ROWS[i].op)
        2'h0: u_far.press(ROWS[i].arg);
        2'h1: u_far.wake(ROWS[i].arg[3:0]);
        default: begin
          oscmd_i = ROWS[i].arg[2:0];
          @(negedge mclk_i);
          oscmd_i = '0;
        end
      endcase
      expect_st(ROWS[i].st);
    end
    u_far.press(10);
    repeat (250) @(negedge mclk_i);
    `CHK(tach_cnt[15:0] inside {[16'h31:16'h33]}, 1'b1)
    // Zero duty switches the fans off; half duty is high for half of a full phase turn.
    duty = 8'h00;
    repeat (4) @(negedge mclk_i);
    `CHK(pwm, 4'h0)
    duty = 8'h80;
    repeat (4) @(negedge mclk_i);
    repeat (256) begin
      @(negedge mclk_i);
      hi_cnt += pwm[0];
    end
    `CHK(hi_cnt, 128)
    duty = 8'hFF;
    repeat (4) @(negedge mclk_i);
    // Mode 3 must act as off; the last pass has no saved on-state.
    for (int m = 0; m < 5; m++) begin
      rst_i = 1'b1;
      restore_mode_i = m[1:0];
      last_on_i = (m < 4);
      repeat (6) @(negedge mclk_i);
      rst_i = 1'b0;
      expect_st((m == 0 || m == 2) ? PST_S0 : PST_S5);
      `CHK(wake_pwr, 1'b1)
    end
    stop_test();
  end
endmodule // bpsc_top_tb
`default_nettype wire
